// File: common/lsb_pkg.sv
// package: register map, field layout and state encoding for the sync/bias/pixel-clock timing block
package lsb_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TIMING2 = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	// control register fields
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_ACTIVE_MODE = 1;
	localparam int CTRL_PARALLEL_IN = 2;
	// timing register fields
	localparam int T2_DIVIDER_LSB = 0;
	localparam int T2_BIAS_PERIOD_LSB = 8;
	localparam int T2_BIAS_IRQ_COUNT_LSB = 16;
	localparam int T2_PIXEL_CLOCK_INVERT = 22;
	localparam int T2_SYNC_EDGE_SELECT = 24;
	localparam int T2_SYNC_EDGE_OVERRIDE_EN = 25;
	localparam logic [31:0] T2_WRITE_MASK = 32'h034F_FFFF;
	localparam logic [31:0] CTRL_WRITE_MASK = 32'h0000_0007;
	// status register fields
	localparam int ST_DISABLED = 0;
	localparam int ST_SYNC_LOST = 2;
	localparam int ST_BIAS_COUNT = 3;
	localparam int ST_UNDERFLOW = 5;
	localparam int ST_OVERRUN = 7;
	localparam int NUM_STICKY_EVT = 3;
	// reset values
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] T2_RESET = 32'h0000_0000;
	// smallest divider the clock generator can realise
	localparam logic [7:0] DIVIDER_MIN = 8'h02;
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [3:0] ZERO4 = 4'h0;
	localparam logic [7:0] ONE8 = 8'h01;
	localparam logic [3:0] ONE4 = 4'h1;
	// controller sequencing, gray along idle -> load -> run
	typedef enum logic [1:0]
	{
		LSB_IDLE = 2'b00,
		LSB_LOAD = 2'b01,
		LSB_RUN = 2'b11
	} lsb_state_t;
endpackage

// File: design/lsb_timing.sv
// sync edge, bias pin and pixel clock generation with apb register slave
//
// Functional notes
// - default: sync on falling, data on rising edge
// - inverted clock: sync rising, data falling edge
// - override enable lets select bit pick sync edge
// - enable loads 4-bit transition count, counts inversions
// - transition counter at zero stops, sets status
// - while status set, counter reloads and holds
// - counts 0..15; zero disables transition interrupt
// - enable loads 8-bit period, decrements per line
// - period counter zero inverts bias pin, reloads
// - active mode: bias pin is data output enable
// - pixel clock is controller clock over divider
// - parallel input: pixel clock drives and latches data
// - any set status bit drives interrupt request
// - sticky bits cleared by writing one only
// - read-only flags ignore software writes
// - status reports fifo, bias, disable, dma sources
// - bias count status sits at status bit 3
// - transition count field at timing bits 19:16
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/100ps
module lsb_timing
	import lsb_pkg::*;
(
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// requests from the frame timing generator
	input wire logic line_clk_pulse,
	input wire logic hsync_req,
	input wire logic vsync_req,
	input wire logic [15:0] pixel_data_in,
	input wire logic pixel_data_valid,
	// fifo and dma events and flags
	input wire logic fifo_overrun_evt,
	input wire logic dma_base_update_evt,
	input wire logic dma_bus_error_evt,
	input wire logic fifo_underflow_flag,
	input wire logic sync_lost_flag,
	// panel pins
	output logic pixel_clock_pin,
	output logic hsync_pin,
	output logic vsync_pin,
	output logic [15:0] pixel_data_pin,
	output logic bias_toggle_pin,
	output logic fifo_latch_strobe,
	output logic lcd_irq
);
	lsb_state_t state_r, state_nxt;
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [31:0] t2_r, t2_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic [NUM_STICKY_EVT-1:0] sticky_r, sticky_nxt;
	logic bias_status_r, bias_status_nxt;
	logic [7:0] div_r, div_nxt;
	logic [7:0] div_cnt_r, div_cnt_nxt;
	logic pix_r, pix_nxt;
	logic [7:0] per_cnt_r, per_cnt_nxt;
	logic [3:0] trn_cnt_r, trn_cnt_nxt;
	logic bias_r, bias_nxt;
	logic hs_r, hs_nxt, vs_r, vs_nxt;
	logic [15:0] data_r, data_nxt;
	logic latch_r, latch_nxt;
	logic irq_r, irq_nxt;
	logic apb_wr, apb_rd;
	logic rise_evt, fall_evt, sync_evt, data_evt;
	logic [NUM_STICKY_EVT-1:0] evt_in, w1c;
	logic [31:0] status_val;

	// true when the address hits a mapped register
	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a == OFS_CTRL) || (a == OFS_TIMING2) || (a == OFS_STATUS);
	endfunction

	// one wait state: the access completes on the second cycle of the access phase
	assign apb_wr = psel && penable && pready_r && pwrite;
	assign apb_rd = psel && penable && !pready_r && !pwrite;

	wire logic en = ctrl_r[CTRL_ENABLE];
	wire logic active_mode = ctrl_r[CTRL_ACTIVE_MODE];
	wire logic [3:0] bias_irq_count = t2_r[T2_BIAS_IRQ_COUNT_LSB +: 4];
	wire logic [7:0] bias_period = t2_r[T2_BIAS_PERIOD_LSB +: 8];
	wire logic [7:0] divider_field = t2_r[T2_DIVIDER_LSB +: 8];
	wire logic clk_invert = t2_r[T2_PIXEL_CLOCK_INVERT];
	wire logic ovr = t2_r[T2_SYNC_EDGE_OVERRIDE_EN];
	wire logic sel = t2_r[T2_SYNC_EDGE_SELECT];

	always_comb
	begin
		status_val = '0;
		status_val[ST_DISABLED] = !en;
		status_val[ST_SYNC_LOST] = sync_lost_flag;
		status_val[ST_BIAS_COUNT] = bias_status_r;
		status_val[ST_UNDERFLOW] = fifo_underflow_flag;
		status_val[ST_OVERRUN +: NUM_STICKY_EVT] = sticky_r;
	end

	// register file and bus answer
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		t2_nxt = t2_r;
		prdata_nxt = prdata_r;
		pready_nxt = psel && penable && !pready_r;
		pslverr_nxt = psel && penable && !pready_r && !reg_hit(paddr);
		if (apb_wr && paddr == OFS_CTRL)
		begin
			ctrl_nxt = pwdata & CTRL_WRITE_MASK;
		end
		if (apb_wr && paddr == OFS_TIMING2)
		begin
			t2_nxt = pwdata & T2_WRITE_MASK;
		end
		if (apb_rd)
		begin
			case (paddr)
				OFS_CTRL: prdata_nxt = ctrl_r;
				OFS_TIMING2: prdata_nxt = t2_r;
				OFS_STATUS: prdata_nxt = status_val;
				default: prdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r <= CTRL_RESET;
			t2_r <= T2_RESET;
			prdata_r <= '0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			t2_r <= t2_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// sticky event bits: a new event wins over a clear in the same cycle
	assign evt_in = {dma_bus_error_evt, dma_base_update_evt, fifo_overrun_evt};
	assign w1c = (apb_wr && paddr == OFS_STATUS && reg_hit(paddr)) ?
		pwdata[ST_OVERRUN +: NUM_STICKY_EVT] : '0;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_STICKY_EVT; gi++)
		begin : g_sticky
			assign sticky_nxt[gi] = evt_in[gi] || (sticky_r[gi] && !w1c[gi]);
		end
	endgenerate

	// controller sequencing
	always_comb
	begin
		case (state_r)
			LSB_IDLE: state_nxt = en ? LSB_LOAD : LSB_IDLE;
			LSB_LOAD: state_nxt = en ? LSB_RUN : LSB_IDLE;
			LSB_RUN: state_nxt = en ? LSB_RUN : LSB_IDLE;
			default: state_nxt = LSB_IDLE;
		endcase
	end

	// pixel clock: high from count 0, low from half way; divider captured at load
	assign rise_evt = (state_r == LSB_RUN) && (div_cnt_r == ZERO8);
	assign fall_evt = (state_r == LSB_RUN) && (div_cnt_r == (div_r >> 1));
	assign sync_evt = ovr ? (sel ? rise_evt : fall_evt) : (clk_invert ? rise_evt : fall_evt);
	assign data_evt = clk_invert ? fall_evt : rise_evt;

	always_comb
	begin
		div_nxt = div_r;
		div_cnt_nxt = ZERO8;
		pix_nxt = 1'b0;
		case (state_r)
			LSB_LOAD:
			begin
				div_nxt = (divider_field < DIVIDER_MIN) ? DIVIDER_MIN : divider_field;
			end
			LSB_RUN:
			begin
				div_cnt_nxt = (div_cnt_r == div_r - ONE8) ? ZERO8 : div_cnt_r + ONE8;
				pix_nxt = rise_evt ? 1'b1 : (fall_evt ? 1'b0 : pix_r);
			end
			default:
			begin
				div_nxt = div_r;
			end
		endcase
	end

	// sync and data outputs follow their chosen pixel clock edge
	always_comb
	begin
		hs_nxt = sync_evt ? hsync_req : hs_r;
		vs_nxt = sync_evt ? vsync_req : vs_r;
		data_nxt = data_evt ? (pixel_data_valid ? pixel_data_in : '0) : data_r;
		latch_nxt = ctrl_r[CTRL_PARALLEL_IN] && data_evt;
		if (state_r != LSB_RUN)
		begin
			hs_nxt = 1'b0;
			vs_nxt = 1'b0;
			data_nxt = '0;
		end
	end

	// bias pin and its two counters
	always_comb
	begin
		per_cnt_nxt = per_cnt_r;
		trn_cnt_nxt = trn_cnt_r;
		bias_nxt = bias_r;
		bias_status_nxt = bias_status_r;
		case (state_r)
			LSB_LOAD:
			begin
				per_cnt_nxt = bias_period;
				trn_cnt_nxt = bias_irq_count;
			end
			LSB_RUN:
			begin
				if (active_mode)
				begin
					// period is ignored; pin marks the beats on which data is driven
					if (data_evt)
					begin
						bias_nxt = pixel_data_valid;
					end
				end
				else if (line_clk_pulse)
				begin
					if (per_cnt_r == ZERO8)
					begin
						bias_nxt = !bias_r;
						per_cnt_nxt = bias_period;
					end
					else
					begin
						per_cnt_nxt = per_cnt_r - ONE8;
					end
				end
				if (bias_status_r || bias_irq_count == ZERO4)
				begin
					trn_cnt_nxt = bias_irq_count;
				end
				else if (bias_nxt != bias_r && trn_cnt_r != ZERO4)
				begin
					trn_cnt_nxt = trn_cnt_r - ONE4;
					if (trn_cnt_r == ONE4)
					begin
						bias_status_nxt = 1'b1;
					end
				end
			end
			default:
			begin
				bias_nxt = 1'b0;
			end
		endcase
		// a set in this cycle wins over the software clear
		if (apb_wr && paddr == OFS_STATUS && pwdata[ST_BIAS_COUNT] && bias_status_nxt == bias_status_r)
		begin
			bias_status_nxt = 1'b0;
		end
	end

	// any set status bit or flag holds the request
	assign irq_nxt = |{sticky_nxt, bias_status_nxt, !ctrl_nxt[CTRL_ENABLE], sync_lost_flag, fifo_underflow_flag};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= LSB_IDLE;
			sticky_r <= '0;
			bias_status_r <= 1'b0;
			div_r <= DIVIDER_MIN;
			div_cnt_r <= ZERO8;
			pix_r <= 1'b0;
			per_cnt_r <= ZERO8;
			trn_cnt_r <= ZERO4;
			bias_r <= 1'b0;
			hs_r <= 1'b0;
			vs_r <= 1'b0;
			data_r <= '0;
			latch_r <= 1'b0;
			irq_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			sticky_r <= sticky_nxt;
			bias_status_r <= bias_status_nxt;
			div_r <= div_nxt;
			div_cnt_r <= div_cnt_nxt;
			pix_r <= pix_nxt;
			per_cnt_r <= per_cnt_nxt;
			trn_cnt_r <= trn_cnt_nxt;
			bias_r <= bias_nxt;
			hs_r <= hs_nxt;
			vs_r <= vs_nxt;
			data_r <= data_nxt;
			latch_r <= latch_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign pixel_clock_pin = pix_r;
	assign hsync_pin = hs_r;
	assign vsync_pin = vs_r;
	assign pixel_data_pin = data_r;
	assign bias_toggle_pin = bias_r;
	assign fifo_latch_strobe = latch_r;
	assign lcd_irq = irq_r;
endmodule

// File: test/lsb_timing_properties.sv
// checker: apb handshake, sync pin timing and interrupt relations of the timing block
`timescale 1ns/100ps
module lsb_timing_properties
	import lsb_pkg::*;
(
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// status sources
	input wire logic fifo_overrun_evt,
	input wire logic sync_lost_flag,
	// pins
	input wire logic pixel_clock_pin,
	input wire logic hsync_pin,
	input wire logic lcd_irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic mapped;
	assign mapped = paddr == OFS_CTRL || paddr == OFS_TIMING2 || paddr == OFS_STATUS;
	ready_wait_a: assert property (psel && !penable |=> psel && penable && !pready ##1 pready)
		else $error("pready not in second access cycle");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	unmapped_err_a: assert property (pready && !mapped |-> pslverr)
		else $error("unmapped access without error");
	mapped_ok_a: assert property (pready && mapped |-> !pslverr)
		else $error("error on mapped access");
	unmapped_zero_a: assert property (pready && !mapped && !pwrite |-> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	irq_flag_a: assert property (sync_lost_flag [*3] |-> lcd_irq)
		else $error("flag does not raise interrupt");
	irq_event_a: assert property (fifo_overrun_evt |-> ##[1:3] lcd_irq)
		else $error("sticky event does not raise interrupt");
	sync_edge_a: assert property ($changed(hsync_pin) |-> $changed(pixel_clock_pin))
		else $error("sync pin moved off a pixel clock edge");
endmodule
bind lsb_timing lsb_timing_properties props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.fifo_overrun_evt(fifo_overrun_evt), .sync_lost_flag(sync_lost_flag), .pixel_clock_pin(pixel_clock_pin),
	.hsync_pin(hsync_pin), .lcd_irq(lcd_irq));

// File: test/lsb_panel_model.sv
// panel model: counts bias flips and feeds parallel input data on each pixel clock rise
`timescale 1ns/100ps
module lsb_panel_model
(
	// panel pins
	input wire logic pclk,
	input wire logic pixel_clock_pin,
	input wire logic bias_toggle_pin,
	// parallel source and flip count
	output logic [15:0] pixel_data_in,
	output int bias_flips
);
	logic last_bias = 1'b0;
	logic last_pck = 1'b0;
	initial
	begin
		pixel_data_in = 16'h0000;
		bias_flips = 0;
	end
	always @(posedge pclk)
	begin
		if (bias_toggle_pin != last_bias)
			bias_flips <= bias_flips + 1;
		// new word per pixel clock, so a stale latch would show
		if (pixel_clock_pin && !last_pck)
			pixel_data_in <= pixel_data_in + 16'h0001;
		last_bias <= bias_toggle_pin;
		last_pck <= pixel_clock_pin;
	end
endmodule

// File: test/lsb_timing_bench.sv
// bench: registers, pixel clock, sync edges, bias counting and status of the timing block
`timescale 1ns/100ps
module lsb_timing_bench
	import lsb_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic line = 1'b0, hreq = 1'b0, valid = 1'b0, e;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic pready, pslverr, pck, hs, vs, bias, strobe, irq;
	logic [15:0] din, dpin;
	logic [2:0] evt = 3'h0;
	logic [1:0] flg = 2'h0;
	logic [4:0] pins;
	int flips, fail_count = 0, compares = 0;
	// index 4 is the bus answer, waited on by every transfer
	assign pins = {pready, pck, strobe, bias, hs};
	always #12.5 pclk = ~pclk;
	lsb_timing dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.line_clk_pulse(line), .hsync_req(hreq), .vsync_req(hreq), .pixel_data_in(din),
		.pixel_data_valid(valid), .fifo_overrun_evt(evt[0]), .dma_base_update_evt(evt[1]),
		.dma_bus_error_evt(evt[2]), .fifo_underflow_flag(flg[0]), .sync_lost_flag(flg[1]),
		.pixel_clock_pin(pck), .hsync_pin(hs), .vsync_pin(vs), .pixel_data_pin(dpin),
		.bias_toggle_pin(bias), .fifo_latch_strobe(strobe), .lcd_irq(irq));
	lsb_panel_model panel (.pclk(pclk), .pixel_clock_pin(pck), .bias_toggle_pin(bias),
		.pixel_data_in(din), .bias_flips(flips));
	task automatic stop_test();
		$display("fail_count=%0d compares=%0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] x, input logic [31:0] got);
		compares++;
		if (got !== x)
		begin
			fail_count++;
			$display("BAD t=%0t exp=%h got=%h", $time, x, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// waits until a pin shows a level; a hang ends the run
	task automatic until_pin(input int s, input logic v);
		int n;
		n = 0;
		while (pins[s] !== v)
		begin
			n++;
			if (n > 400)
			begin
				fail_count++;
				stop_test();
			end
			@(posedge pclk);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		until_pin(4, 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		chk(x, q & m);
	endtask
	task automatic cfg(input logic [31:0] c, input logic [31:0] t);
		apb(1'b1, OFS_CTRL, 32'h0000_0000);
		apb(1'b1, OFS_TIMING2, t);
		apb(1'b1, OFS_CTRL, c);
		// enable passes through the load state; line pulses there would be lost
		tick(2);
	endtask
	task automatic lines(input int n);
		repeat (n)
		begin
			line <= 1'b1;
			@(posedge pclk);
			line <= 1'b0;
			tick(3);
		end
	endtask
	task automatic regs_check();
		rd(OFS_CTRL, 32'hFFFF_FFFF, CTRL_RESET);
		rd(OFS_TIMING2, 32'hFFFF_FFFF, T2_RESET);
		rd(OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0001);
		rd(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000);
		chk(32'h0000_0001, {31'h0, e});
		apb(1'b1, OFS_TIMING2, 32'hFFFF_FFFF);
		rd(OFS_TIMING2, 32'hFFFF_FFFF, T2_WRITE_MASK);
	endtask
	task automatic clock_check();
		time t0;
		cfg(32'h0000_0001, 32'h0000_0004);
		until_pin(3, 1'b0);
		until_pin(3, 1'b1);
		t0 = $time;
		until_pin(3, 1'b0);
		until_pin(3, 1'b1);
		chk(32'h0000_0064, 32'($time - t0));
		apb(1'b1, OFS_CTRL, 32'h0000_0000);
		tick(8);
		chk(32'h0000_0000, {31'h0, pck});
	endtask
	task automatic sync_check();
		logic [2:0] tab [4] = '{3'b000, 3'b001, 3'b110, 3'b101};
		for (int i = 0; i < 4; i++)
		begin
			cfg(32'h0000_0001, {6'h00, tab[i][2], tab[i][1], 1'b0, tab[i][0], 22'h00_0004});
			hreq <= 1'b1;
			until_pin(0, 1'b1);
			chk({31'h0, tab[i][2] ? tab[i][1] : tab[i][0]}, {31'h0, pck});
			chk(32'h0000_0001, {31'h0, vs});
			hreq <= 1'b0;
			until_pin(0, 1'b0);
		end
	endtask
	task automatic bias_check();
		int f;
		cfg(32'h0000_0001, 32'h0002_0104);
		f = flips;
		lines(2);
		tick(4);
		chk(f + 1, flips);
		lines(2);
		tick(4);
		chk(f + 2, flips);
		rd(OFS_STATUS, 32'h0000_0008, 32'h0000_0008);
		chk(32'h0000_0001, {31'h0, irq});
		lines(4);
		apb(1'b1, OFS_STATUS, 32'h0000_0000);
		rd(OFS_STATUS, 32'h0000_0008, 32'h0000_0008);
		apb(1'b1, OFS_STATUS, 32'h0000_0008);
		rd(OFS_STATUS, 32'h0000_0009, 32'h0000_0000);
		chk(32'h0000_0000, {31'h0, irq});
		lines(2);
		rd(OFS_STATUS, 32'h0000_0008, 32'h0000_0000);
		lines(2);
		rd(OFS_STATUS, 32'h0000_0008, 32'h0000_0008);
		cfg(32'h0000_0001, 32'h0000_0104);
		apb(1'b1, OFS_STATUS, 32'h0000_0008);
		lines(4);
		rd(OFS_STATUS, 32'h0000_0008, 32'h0000_0000);
	endtask
	task automatic status_check();
		evt <= 3'h7;
		flg <= 2'h3;
		@(posedge pclk);
		evt <= 3'h0;
		tick(2);
		rd(OFS_STATUS, 32'h0000_03A4, 32'h0000_03A4);
		apb(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
		rd(OFS_STATUS, 32'h0000_03AC, 32'h0000_0024);
		flg <= 2'h0;
		tick(2);
		rd(OFS_STATUS, 32'h0000_0024, 32'h0000_0000);
	endtask
	task automatic mode_check();
		time t0;
		cfg(32'h0000_0003, 32'h0000_FF04);
		until_pin(1, 1'b0);
		valid <= 1'b1;
		until_pin(1, 1'b1);
		valid <= 1'b0;
		until_pin(1, 1'b0);
		valid <= 1'b1;
		cfg(32'h0000_0005, 32'h0000_0004);
		until_pin(2, 1'b1);
		chk({16'h0000, din}, {16'h0000, dpin});
		t0 = $time;
		@(posedge pclk);
		until_pin(2, 1'b1);
		chk(32'h0000_0064, 32'($time - t0));
		valid <= 1'b0;
	endtask
	initial
	begin
		tick(6);
		presetn <= 1'b1;
		@(posedge pclk);
		regs_check();
		clock_check();
		sync_check();
		bias_check();
		status_check();
		mode_check();
		stop_test();
	end
endmodule
